// [acc_pkg.sv]
// Package of constants and types for the converter control block
// ----------------------------------------------------------------------------
// Functional notes
// RQ1 - Any control write aborts current conversion and starts new unless selector all ones; hardware mode here only aborts and waits for a trigger rise.
// RQ2 - Compare disabled: done flag bit 7 sets at every conversion completion.
// RQ3 - Compare enabled: done flag sets at completion only when compare is true.
// RQ4 - Done flag clears on control register write and on low result read.
// RQ5 - Interrupt enable bit 6 raises interrupt when done flag sets while enabled.
// RQ6 - Continuous bit 5 clear: exactly one conversion per write or hardware trigger.
// RQ7 - Continuous bit set: back-to-back conversions after write or hardware trigger event; hardware mode here starts one per trigger rise.
// RQ8 - Selector bits 4:0: codes 0-27 inputs, 28 reserved, 29 high ref, 30 low ref.
// RQ9 - Selector all ones powers converter off and isolates input from all sources.
// RQ10 - Writing all-ones selector stops continuous conversions with no extra conversion.
// RQ11 - Single mode: converter enters low power automatically after conversion completes.
// RQ12 - Trigger select picks software write start or hardware trigger input start.
// RQ13 - Conversion active bit sets at start, clears at completion or abort.
// RQ14 - Hardware trigger is periodic counter overflow, independent of counter irq enable.
// RQ15 - Interrupt level stays high while done flag and enable both set.
// ----------------------------------------------------------------------------
package acc_pkg;
   // Register byte addresses
   localparam logic [7:0] ACC_OFF_SC1 = 8'h00;
   localparam logic [7:0] ACC_OFF_SC2 = 8'h04;
   localparam logic [7:0] ACC_OFF_RESULT_LOW = 8'h08;
   localparam logic [7:0] ACC_OFF_RESULT_HIGH = 8'h0C;
   localparam logic [7:0] ACC_OFF_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ACC_OFF_IRQ_MASK = 8'h14;
   // Control register fields
   localparam int ACC_BIT_DONE = 7;
   localparam int ACC_BIT_IEN = 6;
   localparam int ACC_BIT_CONT = 5;
   localparam int ACC_SEL_MSB = 4;
   // Second register fields
   localparam int ACC_BIT_ACTIVE = 7;
   localparam int ACC_BIT_TRIG = 6;
   localparam int ACC_BIT_CMPEN = 5;
   // Selector codes
   localparam logic [4:0] ACC_SEL_LAST_INPUT = 5'h1B;
   localparam logic [4:0] ACC_SEL_RESERVED = 5'h1C;
   localparam logic [4:0] ACC_SEL_HIGH_REF = 5'h1D;
   localparam logic [4:0] ACC_SEL_LOW_REF = 5'h1E;
   localparam logic [4:0] ACC_SEL_OFF = 5'h1F;
   // Reset values
   localparam logic [4:0] ACC_SEL_RESET = 5'h1F;
   localparam logic [1:0] ACC_IRQ_RESET = 2'h0;
   // Interrupt status bits: done event, abort event
   localparam int ACC_IRQ_DONE = 0;
   localparam int ACC_IRQ_ABORT = 1;
   // Width of result from the analog core
   localparam int ACC_RES_W = 10;
   typedef enum logic [1:0] {ACC_IDLE, ACC_CONVERT, ACC_WAIT} acc_state_type;
endpackage

// [acc_sync2.sv]
// Two flip-flop synchroniser for one level
`timescale 1ns/1ps
module acc_sync2 (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic d_in,
   output logic q_out
);
   logic s1_ff;
   logic s2_ff;
   logic nxt_s1;
   logic nxt_s2;
   // First stage feeds only the second stage
   always_comb begin
      nxt_s1 = d_in;
      nxt_s2 = s1_ff;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
      end else begin
         s1_ff <= nxt_s1;
         s2_ff <= nxt_s2;
      end
   end
   assign q_out = s2_ff;
endmodule

// [acc_sticky_irq.sv]
// Sticky status bits with mask and write-one-to-clear
`timescale 1ns/1ps
module acc_sticky_irq #(
   parameter int W = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] event_in,
   input wire logic [W-1:0] clear_in,
   input wire logic mask_we,
   input wire logic [W-1:0] mask_wdata,
   output logic [W-1:0] status_out,
   output logic [W-1:0] mask_out,
   output logic irq_out
);
   logic [W-1:0] status_ff;
   logic [W-1:0] mask_ff;
   logic [W-1:0] nxt_status;
   logic [W-1:0] nxt_mask;
   // Set wins over a clear in the same cycle so no event is lost
   always_comb begin
      nxt_status = (status_ff & ~clear_in) | event_in;
      nxt_mask = mask_we ? mask_wdata : mask_ff;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_ff <= '0;
         mask_ff <= '0;
      end else begin
         status_ff <= nxt_status;
         mask_ff <= nxt_mask;
      end
   end
   assign status_out = status_ff;
   assign mask_out = mask_ff;
   assign irq_out = |(status_ff & mask_ff);
endmodule

// [acc_conv_ctrl.sv]
// Conversion control, status register and APB slave of the converter
`timescale 1ns/1ps
module acc_conv_ctrl
   import acc_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic hw_trigger_in,
   output logic conv_start,
   output logic conv_abort,
   output logic [4:0] input_select,
   output logic core_power_on,
   input wire logic core_done,
   input wire logic [9:0] core_result,
   input wire logic compare_true,
   output logic done_irq,
   output logic event_irq
);
   // ------------------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------------------
   logic acc_en;
   logic wr_sc1;
   logic wr_sc2;
   logic rd_low;
   logic wr_mask;
   logic wr_stat;
   logic hit;
   assign acc_en = psel & penable;
   assign hit = (paddr == ACC_OFF_SC1) || (paddr == ACC_OFF_SC2) ||
      (paddr == ACC_OFF_RESULT_LOW) || (paddr == ACC_OFF_RESULT_HIGH) ||
      (paddr == ACC_OFF_IRQ_STATUS) || (paddr == ACC_OFF_IRQ_MASK);
   assign wr_sc1 = acc_en & pwrite & (paddr == ACC_OFF_SC1);
   assign wr_sc2 = acc_en & pwrite & (paddr == ACC_OFF_SC2);
   assign rd_low = acc_en & ~pwrite & (paddr == ACC_OFF_RESULT_LOW);
   assign wr_mask = acc_en & pwrite & (paddr == ACC_OFF_IRQ_MASK);
   assign wr_stat = acc_en & pwrite & (paddr == ACC_OFF_IRQ_STATUS);
   // Zero wait states; unmapped addresses answer with an error
   assign pready = 1'b1;
   assign pslverr = acc_en & ~hit;

   // ------------------------------------------------------------------------
   // Hardware trigger synchroniser and edge detect
   // ------------------------------------------------------------------------
   logic trig_sync;
   logic trig_d_ff;
   logic nxt_trig_d;
   logic trig_rise;
   acc_sync2 u_trig_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d_in(hw_trigger_in),
      .q_out(trig_sync)
   );
   // Counter overflow pulse arrives as a rising edge on the trigger pin
   always_comb begin
      nxt_trig_d = trig_sync;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trig_d_ff <= 1'b0;
      end else begin
         trig_d_ff <= nxt_trig_d;
      end
   end
   assign trig_rise = trig_sync & ~trig_d_ff; // RQ14

   // ------------------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------------------
   logic ien_ff;
   logic cont_ff;
   logic [4:0] sel_ff;
   logic trig_ff;
   logic cmpen_ff;
   logic done_ff;
   logic [9:0] result_ff;
   logic nxt_ien;
   logic nxt_cont;
   logic [4:0] nxt_sel;
   logic nxt_trig;
   logic nxt_cmpen;
   logic nxt_done;
   logic [9:0] nxt_result;
   logic done_set;
   logic new_sel_off;
   assign new_sel_off = (pwdata[ACC_SEL_MSB:0] == ACC_SEL_OFF);
   // Done flag: a completion in the same cycle as a clear still sets it
   always_comb begin
      nxt_ien = ien_ff;
      nxt_cont = cont_ff;
      nxt_sel = sel_ff;
      nxt_trig = trig_ff;
      nxt_cmpen = cmpen_ff;
      nxt_done = done_ff;
      nxt_result = result_ff;
      if (wr_sc1) begin
         nxt_ien = pwdata[ACC_BIT_IEN];
         nxt_cont = pwdata[ACC_BIT_CONT];
         nxt_sel = pwdata[ACC_SEL_MSB:0]; // RQ8
      end
      if (wr_sc2) begin
         nxt_trig = pwdata[ACC_BIT_TRIG]; // RQ12
         nxt_cmpen = pwdata[ACC_BIT_CMPEN];
      end
      if (wr_sc1 || rd_low) begin
         nxt_done = 1'b0; // RQ4
      end
      if (done_set) begin
         nxt_done = 1'b1;
         nxt_result = core_result;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ien_ff <= 1'b0;
         cont_ff <= 1'b0;
         sel_ff <= ACC_SEL_RESET;
         trig_ff <= 1'b0;
         cmpen_ff <= 1'b0;
         done_ff <= 1'b0;
         result_ff <= '0;
      end else begin
         ien_ff <= nxt_ien;
         cont_ff <= nxt_cont;
         sel_ff <= nxt_sel;
         trig_ff <= nxt_trig;
         cmpen_ff <= nxt_cmpen;
         done_ff <= nxt_done;
         result_ff <= nxt_result;
      end
   end

   // ------------------------------------------------------------------------
   // Conversion sequencer
   // ------------------------------------------------------------------------
   acc_state_type state_ff;
   acc_state_type nxt_state;
   logic start_ff;
   logic nxt_start;
   logic abort_ff;
   logic nxt_abort;
   logic armed_ff;
   logic nxt_armed;
   logic completes;
   // Completion counts only while converting; stale done after abort is ignored
   assign completes = (state_ff == ACC_CONVERT) && core_done;
   assign done_set = completes && (!cmpen_ff || compare_true); // RQ2 RQ3
   // A control write restarts unless it disables; hardware mode waits for trigger
   always_comb begin
      nxt_state = state_ff;
      nxt_start = 1'b0;
      nxt_abort = 1'b0;
      nxt_armed = armed_ff;
      case (state_ff)
         ACC_IDLE: begin
            if (!trig_ff && armed_ff && sel_ff != ACC_SEL_OFF) begin
               nxt_state = ACC_CONVERT;
               nxt_start = 1'b1;
               nxt_armed = 1'b0;
            end else if (trig_ff && trig_rise && sel_ff != ACC_SEL_OFF) begin
               nxt_state = ACC_CONVERT; // RQ14
               nxt_start = 1'b1;
            end
         end
         ACC_CONVERT: begin
            if (completes) begin
               if (cont_ff && !trig_ff) begin
                  nxt_start = 1'b1; // RQ7
               end else if (cont_ff) begin
                  nxt_state = ACC_WAIT; // RQ7
               end else begin
                  nxt_state = ACC_IDLE; // RQ6 RQ11
               end
            end
         end
         ACC_WAIT: begin
            if (trig_rise) begin
               nxt_state = ACC_CONVERT;
               nxt_start = 1'b1;
            end
         end
         default: nxt_state = ACC_IDLE;
      endcase
      // A control register write overrides whatever the sequencer chose
      if (wr_sc1) begin
         nxt_abort = (state_ff == ACC_CONVERT); // RQ1
         nxt_start = 1'b0;
         nxt_armed = !new_sel_off;
         if (new_sel_off) begin
            nxt_state = ACC_IDLE; // RQ10
         end else if (trig_ff) begin
            nxt_state = ACC_IDLE;
            nxt_armed = 1'b0;
         end else begin
            nxt_state = ACC_IDLE; // RQ1
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ACC_IDLE;
         start_ff <= 1'b0;
         abort_ff <= 1'b0;
         armed_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         start_ff <= nxt_start;
         abort_ff <= nxt_abort;
         armed_ff <= nxt_armed;
      end
   end
   assign conv_start = start_ff;
   assign conv_abort = abort_ff;
   assign input_select = sel_ff;
   // Core powered only while a conversion or continuous wait is pending
   assign core_power_on = (sel_ff != ACC_SEL_OFF) &&
      (state_ff != ACC_IDLE || armed_ff); // RQ9 RQ11
   logic active;
   assign active = (state_ff == ACC_CONVERT); // RQ13

   // ------------------------------------------------------------------------
   // Interrupts
   // ------------------------------------------------------------------------
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [1:0] irq_ev;
   assign irq_ev = {abort_ff, done_set};
   acc_sticky_irq #(.W(2)) u_irq (
      .pclk(pclk),
      .presetn(presetn),
      .event_in(irq_ev),
      .clear_in(wr_stat ? pwdata[1:0] : 2'h0),
      .mask_we(wr_mask),
      .mask_wdata(pwdata[1:0]),
      .status_out(irq_stat),
      .mask_out(irq_mask),
      .irq_out(event_irq)
   );
   assign done_irq = done_ff & ien_ff; // RQ5 RQ15

   // ------------------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------------------
   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      case (paddr)
         ACC_OFF_SC1: rdata = {24'h000000, done_ff, ien_ff, cont_ff, sel_ff};
         ACC_OFF_SC2: rdata = {24'h000000, active, trig_ff, cmpen_ff, 5'h00};
         ACC_OFF_RESULT_LOW: rdata = {24'h000000, result_ff[7:0]};
         ACC_OFF_RESULT_HIGH: rdata = {22'h000000, result_ff};
         ACC_OFF_IRQ_STATUS: rdata = {30'h00000000, irq_stat};
         ACC_OFF_IRQ_MASK: rdata = {30'h00000000, irq_mask};
         default: rdata = 32'h0000_0000;
      endcase
   end
   // Read word captured in the setup cycle so the bus sees a flop; held through access
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   always_comb begin
      nxt_prdata = prdata_ff;
      if (!psel) begin
         nxt_prdata = 32'h0000_0000;
      end else if (!penable) begin
         nxt_prdata = pwrite ? 32'h0000_0000 : rdata;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= 32'h0000_0000;
      end else begin
         prdata_ff <= nxt_prdata;
      end
   end
   assign prdata = prdata_ff;

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   property p_write_clears_done;
      @(posedge pclk) disable iff (!presetn) (wr_sc1 && !done_set) |=> !done_ff;
   endproperty
   a_write_clears_done: assert property (p_write_clears_done) else $error("done not cleared"); // RQ4
   property p_done_nocmp;
      @(posedge pclk) disable iff (!presetn)
         (completes && !cmpen_ff) |=> done_ff;
   endproperty
   a_done_nocmp: assert property (p_done_nocmp) else $error("done not set"); // RQ2
   property p_done_cmp_false;
      @(posedge pclk) disable iff (!presetn)
         (completes && cmpen_ff && !compare_true && !done_ff) |=> !done_ff;
   endproperty
   a_done_cmp_false: assert property (p_done_cmp_false) else $error("done set falsely"); // RQ3
   property p_irq_level;
      @(posedge pclk) disable iff (!presetn) (done_set && nxt_ien) |=> done_irq;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("irq not raised"); // RQ5
   property p_irq_drop;
      @(posedge pclk) disable iff (!presetn) ((wr_sc1 || rd_low) && !done_set) |=> !done_irq;
   endproperty
   a_irq_drop: assert property (p_irq_drop) else $error("irq not dropped"); // RQ15
   sequence s_start_write;
      wr_sc1 && !new_sel_off && !trig_ff;
   endsequence
   property p_write_starts;
      @(posedge pclk) disable iff (!presetn) s_start_write ##1 !wr_sc1 |=> conv_start;
   endproperty
   a_write_starts: assert property (p_write_starts) else $error("no start"); // RQ1
   property p_off_stops;
      @(posedge pclk) disable iff (!presetn) (wr_sc1 && new_sel_off) |=> !conv_start [*2];
   endproperty
   a_off_stops: assert property (p_off_stops) else $error("extra conversion"); // RQ10
   property p_single_idle;
      @(posedge pclk) disable iff (!presetn)
         (completes && !cont_ff && !wr_sc1) |=> (state_ff == ACC_IDLE) && !conv_start;
   endproperty
   a_single_idle: assert property (p_single_idle) else $error("single did not stop"); // RQ6
   property p_off_power;
      @(posedge pclk) disable iff (!presetn) (sel_ff == ACC_SEL_OFF) |-> !core_power_on;
   endproperty
   a_off_power: assert property (p_off_power) else $error("powered while off"); // RQ9
   property p_active_start;
      @(posedge pclk) disable iff (!presetn) $rose(conv_start) |-> active;
   endproperty
   a_active_start: assert property (p_active_start) else $error("active not set"); // RQ13
endmodule

// [acc_core_model.sv]
// Behavioural model of the analog conversion core facing the control block
`timescale 1ns/1ps
module acc_core_model #(
   parameter int CONV_CYC = 20
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic conv_start,
   input wire logic conv_abort,
   input wire logic [4:0] input_select,
   input wire logic cmp_ok,
   output logic core_done,
   output logic [9:0] core_result,
   output logic compare_true
);
   logic busy_ff;
   int cnt_ff;
   logic [4:0] sel_ff;
   // Result and compare only hold meaning with the done pulse; otherwise inverted garbage
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_ff <= 1'b0;
         cnt_ff <= 0;
         sel_ff <= 5'h00;
         core_done <= 1'b0;
         core_result <= 10'h000;
         compare_true <= 1'b0;
      end else begin
         core_done <= 1'b0;
         core_result <= ~core_result;
         compare_true <= ~compare_true;
         if (conv_start) begin
            busy_ff <= 1'b1;
            cnt_ff <= CONV_CYC;
            sel_ff <= input_select;
         end else if (conv_abort) begin
            busy_ff <= 1'b0;
         end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 1;
            if (cnt_ff == 1) begin
               busy_ff <= 1'b0;
               core_done <= 1'b1;
               core_result <= {sel_ff, 5'h15};
               compare_true <= cmp_ok;
            end
         end
      end
   end
endmodule

// [adc_conversion_control_test.sv]
// Self-checking testbench of the converter control block
`timescale 1ns/1ps
module adc_conversion_control_test;
   import acc_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, hw_trigger_in, cmp_ok;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, slv, conv_start, conv_abort, core_power_on;
   logic core_done, compare_true, done_irq, event_irq;
   logic [4:0] input_select;
   logic [9:0] core_result;
   int err_total, tests_run, n_start, n_abort, s, k;
   logic [4:0] codes [5] = '{5'h00, 5'h1B, 5'h1C, 5'h1D, 5'h1E};

   acc_conv_ctrl i_acc_conv_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hw_trigger_in(hw_trigger_in),
      .conv_start(conv_start), .conv_abort(conv_abort), .input_select(input_select),
      .core_power_on(core_power_on), .core_done(core_done), .core_result(core_result),
      .compare_true(compare_true), .done_irq(done_irq), .event_irq(event_irq));
   acc_core_model #(.CONV_CYC(20)) i_acc_core_model (.pclk(pclk), .presetn(presetn),
      .conv_start(conv_start), .conv_abort(conv_abort), .input_select(input_select),
      .cmp_ok(cmp_ok), .core_done(core_done), .core_result(core_result),
      .compare_true(compare_true));

   // Clock of 10 ns
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // Count starts and aborts seen by the core
   always @(posedge pclk) begin
      if (conv_start === 1'b1) n_start++;
      if (conv_abort === 1'b1) n_abort++;
   end
   // Watchdog, well beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge pclk);
      err_total++;
      test_done();
   end

   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Waits for the core's done pulse, bounded, then lets the flag land
   task automatic wait_done();
      int i;
      i = 0;
      while (core_done !== 1'b1 && i < 200) begin
         @(posedge pclk);
         i++;
      end
      chk("core_done_seen", 1, i < 200);
      repeat (2) @(posedge pclk);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Test sequence
   // ---------------------------------------------------------------
   initial begin
      err_total = 0; tests_run = 0; n_start = 0; n_abort = 0;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; hw_trigger_in = 1'b0; cmp_ok = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      // Reset state: converter off, selector disabled
      apb(1'b0, ACC_OFF_SC1, 32'h0); chk("sc1_reset", 32'h0000001F, rd);
      chk("power_reset", 0, core_power_on);
      $display("test reset done");
      // Software single conversion with interrupt enabled
      apb(1'b1, ACC_OFF_IRQ_MASK, 32'h00000001);
      apb(1'b1, ACC_OFF_SC1, 32'h00000043);
      wait_done();
      apb(1'b0, ACC_OFF_SC1, 32'h0); chk("sc1_done", 32'h000000C3, rd);
      chk("done_irq", 1, done_irq);
      chk("event_irq", 1, event_irq);
      repeat (30) @(posedge pclk);
      chk("single_starts", 1, n_start);
      chk("auto_power_off", 0, core_power_on);
      apb(1'b0, ACC_OFF_SC2, 32'h0); chk("active_idle", 0, rd[7]);
      apb(1'b0, ACC_OFF_RESULT_LOW, 32'h0); chk("result_low", 32'h00000075, rd);
      apb(1'b0, ACC_OFF_SC1, 32'h0); chk("sc1_clr_read", 32'h00000043, rd);
      chk("done_irq_low", 0, done_irq);
      apb(1'b1, ACC_OFF_IRQ_STATUS, 32'h00000003);
      apb(1'b0, ACC_OFF_IRQ_STATUS, 32'h0); chk("irq_status_w1c", 0, rd);
      chk("event_irq_low", 0, event_irq);
      $display("test single done");
      // Boundary selector codes; each write after the first lands in mid-conversion, aborts and restarts
      s = n_abort;
      for (k = 0; k < 5; k++) begin
         apb(1'b1, ACC_OFF_SC1, {27'h0, codes[k]});
         repeat (4) @(posedge pclk);
         chk("input_select", codes[k], input_select);
      end
      chk("aborts", 4, n_abort - s);
      apb(1'b0, ACC_OFF_IRQ_STATUS, 32'h0); chk("abort_event", 32'h00000002, rd);
      apb(1'b1, ACC_OFF_SC1, 32'h0000001F);
      $display("test selector done");
      // Continuous conversions, then stop by the disable code
      s = n_start;
      apb(1'b1, ACC_OFF_SC1, 32'h00000025);
      for (k = 0; k < 3; k++) wait_done();
      chk("cont_running", 1, n_start - s >= 3);
      apb(1'b1, ACC_OFF_SC1, 32'h0000003F);
      s = n_start;
      repeat (60) @(posedge pclk);
      chk("cont_stop", s, n_start);
      chk("off_power", 0, core_power_on);
      $display("test continuous done");
      // Compare enabled: flag only when compare holds
      apb(1'b1, ACC_OFF_SC2, 32'h00000020);
      apb(1'b1, ACC_OFF_SC1, 32'h00000002);
      wait_done();
      apb(1'b0, ACC_OFF_SC1, 32'h0); chk("cmp_false", 32'h00000002, rd);
      cmp_ok <= 1'b1;
      apb(1'b1, ACC_OFF_SC1, 32'h00000002);
      wait_done();
      apb(1'b0, ACC_OFF_SC1, 32'h0); chk("cmp_true", 32'h00000082, rd);
      apb(1'b1, ACC_OFF_SC1, 32'h00000002);
      apb(1'b0, ACC_OFF_SC1, 32'h0); chk("sc1_clr_write", 32'h00000002, rd);
      wait_done();
      $display("test compare done");
      // Hardware trigger: write starts nothing and leaves the block unarmed, one overflow starts one
      apb(1'b1, ACC_OFF_SC2, 32'h00000040);
      apb(1'b1, ACC_OFF_SC1, 32'h00000004);
      s = n_start;
      repeat (40) @(posedge pclk);
      chk("hw_no_sw_start", s, n_start);
      hw_trigger_in <= 1'b1;
      repeat (6) @(posedge pclk);
      apb(1'b0, ACC_OFF_SC2, 32'h0); chk("active_busy", 32'h000000C0, rd);
      wait_done();
      hw_trigger_in <= 1'b0;
      repeat (30) @(posedge pclk);
      chk("hw_one_start", s + 1, n_start);
      apb(1'b0, ACC_OFF_SC1, 32'h0); chk("hw_done", 32'h00000084, rd);
      // Hardware continuous: each trigger rise starts one, the block waits powered between
      s = n_start;
      apb(1'b1, ACC_OFF_SC1, 32'h00000024);
      for (k = 0; k < 2; k++) begin
         hw_trigger_in <= 1'b1;
         repeat (3) @(posedge pclk);
         hw_trigger_in <= 1'b0;
         wait_done();
         repeat (30) @(posedge pclk);
         chk("hw_cont_starts", s + k + 1, n_start);
         chk("hw_wait_power", 1, core_power_on);
      end
      apb(1'b1, ACC_OFF_SC1, 32'h0000003F);
      $display("test hardware trigger done");
      // Unmapped address is refused
      apb(1'b0, 8'h18, 32'h0); chk("unmapped_data", 0, rd);
      chk("unmapped_err", 1, slv);
      $display("test unmapped done");
      test_done();
   end
endmodule
